// ==== inc/fpe_pkg.sv ====
// Purpose: Shared constants and types of the flash program/erase control.
// Assumes: 200 MHz clock, APB register access, one aligned word each.
// Notes: Operation list below.
// Operation
// - Setting the emergency-exit bit stops a running write or erase at once.
// - Reads during the recovery wait after an abort are flagged unreliable.
// - Interrupts are never masked by the controller while flash is busy.
// - Bank erase by dummy write also erases info memory after info read.
// - No fetch or execution from flash is served during a bank erase.
// - Flash reads are unreliable when core level field is 00 or 01.
// - Core control resets to 0x02, both supervisor controls to 0x4602.
// - Read meeting settle expiry with low monitor enabled is flagged suspect.
// - CPU is held in wait states until the erase finishes, then released.
package fpe_pkg;
  localparam int ADDR_W = 8;
  localparam int CNT_W = 16;
  localparam logic [7:0] FCTL_OFS = 8'h00;
  localparam logic [7:0] STAT_OFS = 8'h04;
  localparam logic [7:0] CORE_OFS = 8'h08;
  localparam logic [7:0] SVH_OFS = 8'h0c;
  localparam logic [7:0] SVL_OFS = 8'h10;
  localparam logic [7:0] LMON_OFS = 8'h14;
  localparam int FCTL_WRT_BIT = 0;
  localparam int FCTL_ERS_LSB = 1;
  localparam int FCTL_EXIT_BIT = 5;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_RECOV_BIT = 1;
  localparam int STAT_INFO_BIT = 2;
  localparam int STAT_LVL_BIT = 3;
  localparam int STAT_SUSP_BIT = 4;
  localparam int LMON_EN_BIT = 0;
  localparam int LMON_FP_BIT = 1;
  localparam logic [7:0] FCTL_RST = 8'h00;
  localparam logic [15:0] CORE_RST = 16'h0002;
  localparam logic [15:0] SVS_RST = 16'h4602;
  localparam logic [7:0] LMON_RST = 8'h00;
  localparam logic [1:0] CORE_LVL_MIN = 2'h2;
  localparam int CLK_MHZ = 200;
  localparam int BANK_RECOV_US = 100;
  localparam int SEG_RECOV_US = 6;
  localparam int BANK_RECOV_CYC = BANK_RECOV_US * CLK_MHZ;
  localparam int SEG_RECOV_CYC = SEG_RECOV_US * CLK_MHZ;
  typedef enum logic [1:0] {
    ERS_NONE = 2'b00,
    ERS_SEG = 2'b01,
    ERS_BANK = 2'b10,
    ERS_MASS = 2'b11
  } fpe_erase_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WRITE = 2'b01,
    ST_ERASE = 2'b10,
    ST_RECOV = 2'b11
  } fpe_state_t;
endpackage

// ==== inc/fpe_tmr_if.sv ====
// Purpose: Link between the controller and its recovery timer.
// Assumes: Single clock domain.
// Notes: Running already shows in the cycle of the start strobe.
interface fpe_tmr_if;
  import fpe_pkg::*;
  logic start;
  logic [CNT_W-1:0] load;
  logic running;
  modport ctl (output start, output load, input running);
  modport tmr (input start, input load, output running);
endinterface

// ==== design/fpe_recovery_timer.sv ====
// Purpose: Counts the recovery wait after an emergency exit.
// Assumes: Load is at least one cycle.
// Notes: A new start reloads the count.
module fpe_recovery_timer
  import fpe_pkg::*;
(
  // System
  input wire logic clock,
  input wire logic sys_rst,
  // Controller side
  fpe_tmr_if.tmr tmr
);
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;

  always_comb begin
    cnt_d = cnt_q;
    if (tmr.start) begin
      cnt_d = tmr.load;
    end else if (cnt_q != '0) begin
      cnt_d = cnt_q - 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  // Combinational so the controller never sees a gap after the strobe
  assign tmr.running = tmr.start || (cnt_q != '0);

  chk_timer_hold: assert property (@(posedge clock) disable iff (sys_rst)
    tmr.start && tmr.load > 16'h0008 |=> tmr.running [*8])
    else $error("Recovery wait ended too early");
endmodule // fpe_recovery_timer

// ==== design/fpe_flash_ctrl.sv ====
// Purpose: Flash program/erase sequencer with APB registers.
// Assumes: CPU flash port and array on this clock; CPU holds cpuReq.
// Notes: Registers answer in the second access cycle.
//
// Register access over APB and the placing of the registers were left to the implementer.
module fpe_flash_ctrl
  import fpe_pkg::*;
#(
  parameter int BANK_WAIT_CYC = fpe_pkg::BANK_RECOV_CYC
) (
  // System
  input wire logic clock,
  input wire logic sys_rst,
  // APB slave
  input wire logic [fpe_pkg::ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // CPU flash access
  input wire logic cpuReq,
  input wire logic cpuWrite,
  input wire logic cpuFetch,
  input wire logic cpuInfo,
  output logic cpuReady,
  output logic cpuReadOk,
  // Flash array
  input wire logic arrDone,
  output logic arrProgram,
  output logic arrErase,
  output logic [1:0] arrEraseMode,
  output logic arrEraseInfo,
  output logic arrStop,
  // Power and interrupts
  input wire logic coreSettleExpire,
  input wire logic intReqIn,
  output logic intReqOut,
  output logic flashBusy
);
  import fpe_pkg::*;

  fpe_tmr_if tmrLink ();
  fpe_recovery_timer uTimer (
    .clock(clock),
    .sys_rst(sys_rst),
    .tmr(tmrLink.tmr)
  );

  fpe_state_t state_q, state_d;
  logic [7:0] fctl_q, fctl_d, lmon_q, lmon_d;
  logic [15:0] core_q, core_d, svh_q, svh_d, svl_q, svl_d;
  logic infoSeen_q, infoSeen_d, susp_q, susp_d;
  logic [31:0] prdata_q, prdata_d;
  logic pready_q, pready_d, pslverr_q, pslverr_d;
  logic cpuReady_q, cpuReady_d, cpuReadOk_q, cpuReadOk_d;
  logic arrProgram_q, arrProgram_d, arrErase_q, arrErase_d;
  logic [1:0] arrMode_q, arrMode_d;
  logic arrInfo_q, arrInfo_d, arrStop_q, arrStop_d;
  logic intReq_q, busy_q, busy_d;
  logic apbWr, exitHit, accept, levelOk, readStart, mapped;
  logic [31:0] rdVal;
  fpe_erase_t ersMode;

  always_comb begin
    ersMode = fpe_erase_t'(fctl_q[FCTL_ERS_LSB +: 2]);
    levelOk = core_q[1:0] >= CORE_LVL_MIN;
    apbWr = psel && penable && pready_q && pwrite && !pslverr_q;
    exitHit = apbWr && paddr == FCTL_OFS && pwdata[FCTL_EXIT_BIT];
    accept = cpuReq && cpuReady_q;
    readStart = 1'b0;
    mapped = 1'b1;
    rdVal = 32'h0000_0000;
    unique case (paddr)
      FCTL_OFS: rdVal = {24'h000000, fctl_q};
      STAT_OFS: rdVal = {27'h0000000, susp_q, !levelOk, infoSeen_q,
        state_q == ST_RECOV, busy_q};
      CORE_OFS: rdVal = {16'h0000, core_q};
      SVH_OFS: rdVal = {16'h0000, svh_q};
      SVL_OFS: rdVal = {16'h0000, svl_q};
      LMON_OFS: rdVal = {24'h000000, lmon_q};
      default: mapped = 1'b0;
    endcase
    pready_d = psel && penable && !pready_q;
    pslverr_d = pready_d && !mapped;
    prdata_d = (pready_d && !pwrite) ? rdVal : prdata_q;
    fctl_d = fctl_q;
    core_d = core_q;
    svh_d = svh_q;
    svl_d = svl_q;
    lmon_d = lmon_q;
    susp_d = susp_q;
    if (apbWr) begin
      unique case (paddr)
        FCTL_OFS: fctl_d = pwdata[7:0];
        CORE_OFS: core_d = pwdata[15:0];
        SVH_OFS: svh_d = pwdata[15:0];
        SVL_OFS: svl_d = pwdata[15:0];
        LMON_OFS: lmon_d = pwdata[7:0];
        STAT_OFS: if (pwdata[STAT_SUSP_BIT]) susp_d = 1'b0;
        default: ;
      endcase
    end
    state_d = state_q;
    infoSeen_d = infoSeen_q;
    arrProgram_d = 1'b0;
    arrErase_d = 1'b0;
    arrStop_d = 1'b0;
    arrMode_d = arrMode_q;
    arrInfo_d = arrInfo_q;
    tmrLink.start = 1'b0;
    tmrLink.load = CNT_W'(SEG_RECOV_CYC);
    // Wait states whole erase or write, fetches included
    cpuReady_d = cpuReq && !cpuReady_q && state_q != ST_ERASE
      && state_q != ST_WRITE && !accept;
    cpuReadOk_d = cpuReadOk_q;
    if (cpuReady_d && !cpuWrite) begin
      readStart = 1'b1;
      cpuReadOk_d = levelOk && state_q != ST_RECOV
        && !(lmon_q[LMON_EN_BIT] && coreSettleExpire);
    end
    // Set wins over a software clear in the same cycle
    if (readStart && lmon_q[LMON_EN_BIT] && coreSettleExpire) begin
      susp_d = 1'b1;
    end
    unique case (state_q)
      ST_IDLE, ST_RECOV: begin
        if (state_q == ST_RECOV && !tmrLink.running) begin
          state_d = ST_IDLE;
        end
        if (accept && !cpuWrite) begin
          infoSeen_d = cpuInfo;
        end else if (accept && ersMode != ERS_NONE) begin
          state_d = ST_ERASE;
          arrErase_d = 1'b1;
          arrMode_d = ersMode;
          arrInfo_d = ersMode == ERS_BANK && infoSeen_q;
        end else if (accept && fctl_q[FCTL_WRT_BIT]) begin
          state_d = ST_WRITE;
          arrProgram_d = 1'b1;
        end
      end
      ST_WRITE, ST_ERASE: begin
        if (exitHit) begin
          state_d = ST_RECOV;
          arrStop_d = 1'b1;
          tmrLink.start = 1'b1;
          if (state_q == ST_ERASE && arrMode_q != ERS_SEG) begin
            tmrLink.load = CNT_W'(BANK_WAIT_CYC);
          end
        end else if (arrDone) begin
          state_d = ST_IDLE;
        end
      end
    endcase
    busy_d = state_d == ST_WRITE || state_d == ST_ERASE;
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state_q <= ST_IDLE;
      fctl_q <= FCTL_RST;
      core_q <= CORE_RST;
      svh_q <= SVS_RST;
      svl_q <= SVS_RST;
      lmon_q <= LMON_RST;
      infoSeen_q <= 1'b0;
      susp_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      cpuReady_q <= 1'b0;
      cpuReadOk_q <= 1'b0;
      arrProgram_q <= 1'b0;
      arrErase_q <= 1'b0;
      arrMode_q <= ERS_NONE;
      arrInfo_q <= 1'b0;
      arrStop_q <= 1'b0;
      intReq_q <= 1'b0;
      busy_q <= 1'b0;
    end else begin
      state_q <= state_d;
      fctl_q <= fctl_d;
      core_q <= core_d;
      svh_q <= svh_d;
      svl_q <= svl_d;
      lmon_q <= lmon_d;
      infoSeen_q <= infoSeen_d;
      susp_q <= susp_d;
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      cpuReady_q <= cpuReady_d;
      cpuReadOk_q <= cpuReadOk_d;
      arrProgram_q <= arrProgram_d;
      arrErase_q <= arrErase_d;
      arrMode_q <= arrMode_d;
      arrInfo_q <= arrInfo_d;
      arrStop_q <= arrStop_d;
      // Passed on whatever the flash is doing; masking is software's job
      intReq_q <= intReqIn;
      busy_q <= busy_d;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign cpuReady = cpuReady_q;
  assign cpuReadOk = cpuReadOk_q;
  assign arrProgram = arrProgram_q;
  assign arrErase = arrErase_q;
  assign arrEraseMode = arrMode_q;
  assign arrEraseInfo = arrInfo_q;
  assign arrStop = arrStop_q;
  assign intReqOut = intReq_q;
  assign flashBusy = busy_q;

  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  chk_exit_abort: assert property ((state_q == ST_ERASE ||
    state_q == ST_WRITE) && exitHit |=> arrStop_q && state_q == ST_RECOV)
    else $error("Emergency exit did not stop the operation");
  chk_recov_read: assert property (state_q == ST_RECOV && readStart
    |=> !cpuReadOk_q && cpuReady_q)
    else $error("Read during recovery not flagged");
  chk_irq_pass: assert property (intReqIn && busy_q |=> intReqOut)
    else $error("Interrupt request masked while busy");
  chk_info_erase: assert property (accept && cpuWrite
    && state_q == ST_IDLE && ersMode == ERS_BANK
    |=> arrErase_q && arrEraseInfo == $past(infoSeen_q))
    else $error("Info erase choice wrong");
  chk_erase_wait: assert property (state_q == ST_ERASE |=> !cpuReady_q)
    else $error("CPU served during erase");
  chk_erase_free: assert property (state_q == ST_ERASE && arrDone
    && !exitHit |=> state_q == ST_IDLE ##1 (!$past(cpuReq) || cpuReady_q))
    else $error("CPU not released after erase");
  chk_level_read: assert property (readStart && !levelOk
    |=> !cpuReadOk_q)
    else $error("Low core level read marked good");
  chk_reset_vals: assert property (disable iff (1'b0) $fell(sys_rst)
    |-> core_q == CORE_RST && svh_q == SVS_RST && svl_q == SVS_RST)
    else $error("Power control reset values wrong");
  chk_settle_clash: assert property (readStart && coreSettleExpire
    && lmon_q[LMON_EN_BIT] |=> susp_q && !cpuReadOk_q)
    else $error("Settle clash not flagged");
  chk_busy_end: assert property ($fell(busy_q) |-> $past(arrDone)
    || $past(exitHit))
    else $error("Busy dropped without cause");

  cov_bank_erase: cover property (arrErase_q && arrMode_q == ERS_BANK
    ##[1:50] state_q == ST_IDLE);
  cov_abort_recov: cover property (arrStop_q ##[1:60] state_q == ST_IDLE);
  cov_program: cover property (arrProgram_q ##[1:20] arrDone);
  cov_fetch_hold: cover property (cpuFetch && cpuReq && state_q == ST_ERASE);
endmodule // fpe_flash_ctrl

// ==== bench/fpe_cpu_model.sv ====
// Purpose: CPU master model on the flash access port.
// Assumes: One access at a time; the caller keeps the spacing.
// Notes: Idle qualifiers are inverted so stale values never look valid.
module fpe_cpu_model (
  // System
  input wire logic clock,
  // Flash access
  output logic cpuReq,
  output logic cpuWrite,
  output logic cpuFetch,
  output logic cpuInfo,
  input wire logic cpuReady,
  input wire logic cpuReadOk
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    cpuReq = 1'b0;
    cpuWrite = 1'b0;
    cpuFetch = 1'b0;
    cpuInfo = 1'b0;
  end
  // Request held until cpuReady is sampled high, then dropped at that edge
  task automatic access(input logic w, f, i, output bit got, output logic ok);
    int n;
    @(posedge clock);
    cpuReq <= 1'b1;
    cpuWrite <= w;
    cpuFetch <= f;
    cpuInfo <= i & ~f;
    got = 1'b0;
    for (n = 0; n < 4000 && !got; n++) begin
      @(posedge clock);
      got = (cpuReady === 1'b1);
    end
    ok = cpuReadOk;
    cpuReq <= 1'b0;
    cpuWrite <= ~w;
    cpuFetch <= ~f;
    cpuInfo <= ~i;
  endtask
endmodule // fpe_cpu_model

// ==== bench/flash_program_erase_control_tb_top.sv ====
// Purpose: Self-checking bench of the flash program/erase control.
// Assumes: CPU model on the flash port; bench drives APB and the array.
// Notes: Bank recovery shortened to keep the run short.
module flash_program_erase_control_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import fpe_pkg::*;
  localparam int BW = 40;
  logic clock = 1'b0;
  logic sysRst = 1'b1;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, cpuReq, cpuWrite, cpuFetch, cpuInfo, cpuReady;
  logic cpuReadOk, arrProgram, arrErase, arrEraseInfo, arrStop;
  logic [1:0] arrEraseMode;
  logic arrDone = 1'b0;
  logic coreSettleExpire = 1'b0;
  logic intReqIn = 1'b0;
  logic intReqOut, flashBusy, intD, rstD;
  int nFail = 0;
  int nCompared = 0;
  int nErase = 0;
  int nStop = 0;
  int nProg = 0;
  int nPend = 0;
  bit gieOn = 1'b1;
  int lfsr;
  logic [31:0] mdl[6] = '{0, 0, CORE_RST, SVS_RST, SVS_RST, LMON_RST};
  logic [31:0] msk[6] = '{32'hff, 0, 32'hffff, 32'hffff, 32'hffff, 32'hff};
  logic [31:0] fcT[5] = '{4, 4, 2, 6, 1};
  bit infT[5] = '{1, 0, 0, 0, 0};
  logic [31:0] fcA[3] = '{2, 4, 1};
  int wA[3] = '{SEG_RECOV_CYC, BW, SEG_RECOV_CYC};
  always #2.5 clock = ~clock;
  fpe_flash_ctrl #(.BANK_WAIT_CYC(BW)) u_dut (.clock, .sys_rst(sysRst),
    .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
    .cpuReq, .cpuWrite, .cpuFetch, .cpuInfo, .cpuReady, .cpuReadOk,
    .arrDone, .arrProgram, .arrErase, .arrEraseMode, .arrEraseInfo,
    .arrStop, .coreSettleExpire, .intReqIn, .intReqOut, .flashBusy);
  fpe_cpu_model u_cpu (.clock, .cpuReq, .cpuWrite, .cpuFetch, .cpuInfo,
    .cpuReady, .cpuReadOk);
  task automatic chk(input logic [31:0] g, e, input string m);
    nCompared++;
    if (g !== e) begin
      nFail++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, m, g, e);
    end
  endtask
  task automatic endOfTest;
    $display("Compared %0d, failed %0d", nCompared, nFail);
    if (nFail == 0 && nCompared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    // Request stands until pready is sampled high at a rising edge
    for (n = 0; n < 50; n++) begin
      @(posedge clock);
      if (pready === 1'b1) break;
    end
    q = prdata;
    chk(pready, 1, "apb answer");
    chk(pslverr, a >= 8'h18, "slverr");
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    logic [31:0] q;
    apb(1'b0, a, 32'h0, q);
    chk(q, (a < 8'h18) ? mdl[a >> 2] : 32'h0, "read");
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    apb(1'b1, a, d, q);
    if (a < 8'h18) mdl[a >> 2] = d & msk[a >> 2];
  endtask
  // Interrupt copy and wait states are watched on every edge
  always @(posedge clock) begin
    nErase += int'(arrErase === 1'b1);
    nStop += int'(arrStop === 1'b1);
    nProg += int'(arrProgram === 1'b1);
    if (!gieOn && intReqOut === 1'b1) nPend++;
    if (!sysRst && !rstD) chk(intReqOut, intD, "irq copy");
    if (cpuReady === 1'b1 && flashBusy !== 1'b0) chk(1, 0, "wait");
    intD = intReqIn;
    rstD = sysRst;
    lfsr = lfsr * 1103515245 + 12345;
    intReqIn <= lfsr[16];
  end
  initial begin
    repeat (30000) @(posedge clock);
    chk(0, 1, "timeout");
    endOfTest;
  end
  initial begin
    bit got;
    logic ok;
    int i, ne, np, ns;
    lfsr = $urandom(32'hffec785b);
    repeat (3) @(posedge clock);
    sysRst <= 1'b0;
    for (i = 0; i < 7; i++) rd(8'(i * 4));
    wr(8'h18, 32'h1);
    rd(8'h18);
    wr(LMON_OFS, 32'h0);
    wr(SVH_OFS, $urandom & 32'hffff);
    for (i = 0; i < 4; i++) begin
      wr(CORE_OFS, i);
      mdl[1] = 32'(i < 2) << STAT_LVL_BIT;
      rd(STAT_OFS);
    end
    wr(SVL_OFS, $urandom & 32'hffff);
    wr(CORE_OFS, 2);
    mdl[1] = 0;
    for (i = 0; i < 6; i++) rd(8'(i * 4));
    for (i = 0; i < 5; i++) begin
      u_cpu.access(1'b0, 1'b0, infT[i], got, ok);
      mdl[1] = 32'(infT[i]) << STAT_INFO_BIT;
      rd(STAT_OFS);
      gieOn = 1'b0;
      nPend = 0;
      wr(FCTL_OFS, fcT[i]);
      ne = nErase;
      np = nProg;
      u_cpu.access(1'b1, 1'b0, 1'b0, got, ok);
      repeat (2) @(posedge clock);
      chk(nErase - ne, fcT[i][2:1] != 0, "erase start");
      chk(nProg - np, fcT[i] == 1, "program start");
      chk(flashBusy, 1, "busy");
      if (fcT[i] != 1) chk({arrEraseInfo, arrEraseMode},
        {infT[i], fcT[i][2:1]}, "mode");
      fork
        u_cpu.access(1'b0, 1'b1, 1'b0, got, ok);
        begin
          repeat (30) @(posedge clock);
          chk(cpuReq, 1, "held");
          arrDone <= 1'b1;
          @(posedge clock);
          arrDone <= 1'b0;
        end
      join
      chk(got, 1, "fetch served");
      gieOn = 1'b1;
      chk(nPend > 0, 1, "irq while busy");
      chk(flashBusy, 0, "busy end");
      wr(FCTL_OFS, 0);
    end
    wr(FCTL_OFS, 32'h20);
    rd(FCTL_OFS);
    chk(nStop, 0, "idle exit");
    for (i = 0; i < 3; i++) begin
      wr(FCTL_OFS, fcA[i]);
      u_cpu.access(1'b1, 1'b0, 1'b0, got, ok);
      repeat (4) @(posedge clock);
      ns = nStop;
      wr(FCTL_OFS, fcA[i] | 32'h20);
      repeat (2) @(posedge clock);
      chk(nStop - ns, 1, "stop");
      chk(flashBusy, 0, "busy abort");
      mdl[1] = 32'h1 << STAT_RECOV_BIT;
      rd(STAT_OFS);
      wr(FCTL_OFS, 0);
      u_cpu.access(1'b0, 1'b0, 1'b0, got, ok);
      chk(ok, 0, "early read");
      repeat (wA[i] + 4) @(posedge clock);
      u_cpu.access(1'b0, 1'b0, 1'b0, got, ok);
      chk(ok, 1, "late read");
      mdl[1] = 0;
      rd(STAT_OFS);
    end
    for (i = 0; i < 2; i++) begin
      wr(LMON_OFS, i);
      coreSettleExpire <= 1'b1;
      u_cpu.access(1'b0, 1'b0, 1'b0, got, ok);
      coreSettleExpire <= 1'b0;
      chk(ok, i == 0, "settle read");
      mdl[1] = 32'(i) << STAT_SUSP_BIT;
      rd(STAT_OFS);
      wr(STAT_OFS, 32'h10);
      rd(STAT_OFS);
    end
    endOfTest;
  end
endmodule // flash_program_erase_control_tb_top
